// ===== design/i2c_slave_address_receive.sv
/*
 * Two-wire slave: address match, acknowledge control, clock stretching,
 * start/stop detection and software flags.
 * Assumes an external master clocks the bus; software drives the strobes on clk_i.
 */
`timescale 1ns/1ps
module i2c_slave_address_receive (
	input  wire logic                      clk_i,
	input  wire logic                      srst_i,
	input  wire logic                      link_clk_i,
	input  wire logic                      scl_i,
	output logic                           scl_o,
	output logic                           scl_oe_n_o,
	input  wire logic                      sda_i,
	output logic                           sda_o,
	output logic                           sda_oe_n_o,
	input  wire i2c_slave_pkg::control_type ctrl_i,
	input  wire logic                      irq_clear_i,
	input  wire logic                      buffer_read_i,
	input  wire logic                      overflow_clear_i,
	input  wire logic                      clock_release_set_i,
	input  wire logic                      address_we_i,
	input  wire logic [7:0]                address_wdata_i,
	output i2c_slave_pkg::status_type      status_o,
	output logic [7:0]                     own_address_o
);
	import i2c_slave_pkg::*;

	function automatic logic mode_is_ten(input mode_type m);
		return (m == MODE_TEN) || (m == MODE_TEN_SP);
	endfunction

	function automatic logic mode_has_sp(input mode_type m);
		return (m == MODE_SEVEN_SP) || (m == MODE_TEN_SP);
	endfunction

	logic       link_rst;
	logic [1:0] pins_l, pins_s, pulls_l;
	logic       scl_prev_q, sda_prev_q, low_seen_q;
	state_type  state_q;
	phase_type  phase_q;
	logic [3:0] bitcnt_q;
	logic [7:0] shift_q, own_q, buffer_q;
	logic       ack_drive_q, prior_q, hold_used_q;
	logic       irq_q, bf_q, ov_q, ack_rx_q, ack_time_q, ua_q, ckp_q;
	logic       start_q, stop_q, rw_q, da_q, scl_pull_q, sda_pull_q;
	logic       scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
	logic       byte_done, ack_fall, ten, match7, match_hi, match_lo;
	logic       accept, lo_miss, blocked, ack_ok, hold_now, load_ev;
	logic       ua_set, irq_set, ckp_clr;
	logic [7:0] pattern_hi;

	////////////////////////////////////////////////////////////////////////////////
	// link domain: pin sampling and line drivers

	level_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_link_rst (
		.clk_i(link_clk_i), .rst_i(1'b0), .d_i(srst_i), .q_o(link_rst));
	level_sync #(.WIDTH(2), .RESET_VAL(PINS_IDLE)) u_pin_sync (
		.clk_i(link_clk_i), .rst_i(link_rst), .d_i({scl_i, sda_i}), .q_o(pins_l));
	level_sync #(.WIDTH(2), .RESET_VAL(PULLS_NONE)) u_pull_sync (
		.clk_i(link_clk_i), .rst_i(link_rst), .d_i({scl_pull_q, sda_pull_q}), .q_o(pulls_l));

	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			scl_oe_n_o <= 1'b1;
			sda_oe_n_o <= 1'b1;
		end else begin
			scl_oe_n_o <= ~pulls_l[1];
			sda_oe_n_o <= ~pulls_l[0];
		end
		scl_o <= 1'b0;
		sda_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// system domain: bus events

	level_sync #(.WIDTH(2), .RESET_VAL(PINS_IDLE)) u_pin_xing (
		.clk_i(clk_i), .rst_i(srst_i), .d_i(pins_l), .q_o(pins_s));

	assign scl_s    = pins_s[1];
	assign sda_s    = pins_s[0];
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s & low_seen_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// a stop right after a start with no low clock is just the start
	always_ff @(posedge clk_i) begin
		if (srst_i || start_ev) begin
			low_seen_q <= 1'b0;
		end else if (!scl_s) begin
			low_seen_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// address match and acknowledge decision at the eighth falling edge

	assign byte_done = (state_q == ST_RX) && scl_fall && (bitcnt_q == BYTE_BITS);
	assign ack_fall  = (state_q == ST_ACK) && scl_fall;

	always_comb begin
		ten        = mode_is_ten(ctrl_i.port_mode_select);
		pattern_hi = {TEN_HI_PREFIX, own_q[TEN_A9_BIT:TEN_A8_BIT], 1'b0};
		match7     = (((shift_q ^ own_q) & ctrl_i.address_mask & ADDR7_CARE) == 8'h00);
		match_hi   = (shift_q[7:3] == TEN_HI_PREFIX)
			&& ((((shift_q ^ pattern_hi) & ctrl_i.address_mask) & TEN_HI_CARE) == 8'h00);
		match_lo   = (((shift_q ^ own_q) & ctrl_i.address_mask) == 8'h00);
		accept     = 1'b1;
		unique case (phase_q)
			PH_FIRST: accept = ten ? (match_hi && (!shift_q[0] || prior_q)) : match7;
			PH_LOW:   accept = 1'b1;
			PH_DATA:  accept = 1'b1;
		endcase
		lo_miss  = (phase_q == PH_LOW) && !match_lo;
		blocked  = ov_q | (bf_q & ~ctrl_i.buffer_override_enable);
		ack_ok   = accept && !lo_miss && !blocked;
		hold_now = accept && !lo_miss && ((phase_q == PH_DATA) ?
			ctrl_i.data_hold_enable : ctrl_i.address_hold_enable);
		load_ev  = byte_done && accept && !lo_miss && !blocked;
	end

	////////////////////////////////////////////////////////////////////////////////
	// byte engine

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q     <= ST_IDLE;
			phase_q     <= PH_FIRST;
			bitcnt_q    <= 4'h0;
			shift_q     <= 8'h00;
			ack_drive_q <= 1'b0;
			hold_used_q <= 1'b0;
			prior_q     <= 1'b0;
		end else if (start_ev) begin
			state_q  <= ST_RX;
			phase_q  <= PH_FIRST;
			bitcnt_q <= 4'h0;
		end else if (stop_ev) begin
			state_q <= ST_IDLE;
			prior_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (scl_rise && (bitcnt_q < BYTE_BITS)) begin
						shift_q  <= {shift_q[6:0], sda_s};
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (byte_done) begin
						hold_used_q <= hold_now;
						if (phase_q == PH_FIRST && ten && !(match_hi && shift_q[0])) begin
							prior_q <= 1'b0;
						end
						if (!accept) begin
							state_q <= ST_IDLE;
						end else if (hold_now) begin
							state_q <= ST_HOLD;
						end else begin
							ack_drive_q <= ack_ok;
							state_q     <= ST_ACK;
						end
					end
				end
				ST_HOLD: begin
					if (ckp_q) begin
						ack_drive_q <= ~ctrl_i.ack_value_to_send;
						state_q     <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						ack_drive_q <= 1'b0;
						bitcnt_q    <= 4'h0;
						if (!ack_drive_q) begin
							state_q <= ST_IDLE;
						end else if (phase_q == PH_FIRST && shift_q[0]) begin
							state_q <= ST_READ;
						end else begin
							state_q <= ST_RX;
							if (phase_q == PH_LOW) begin
								prior_q <= 1'b1;
							end
							phase_q <= (phase_q == PH_FIRST && ten) ? PH_LOW : PH_DATA;
						end
					end
				end
				// transmit side not built: wait for stop or restart
				ST_READ: begin
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software flags; a hardware event wins over a same-cycle clear

	assign ua_set  = ack_fall && ((phase_q == PH_LOW)
		|| (phase_q == PH_FIRST && ten && ack_drive_q && !shift_q[0]));
	assign irq_set = (byte_done && hold_now) || (ack_fall && (ack_drive_q || !hold_used_q))
		|| (start_ev && (mode_has_sp(ctrl_i.port_mode_select) || ctrl_i.start_irq_enable))
		|| (stop_ev && (mode_has_sp(ctrl_i.port_mode_select) || ctrl_i.stop_irq_enable));
	assign ckp_clr = (byte_done && hold_now) || (ack_fall && ack_drive_q
		&& ((ctrl_i.stretch_enable && !ua_set) || (phase_q == PH_FIRST && shift_q[0])));

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			irq_q <= 1'b0;
		end else if (irq_set) begin
			irq_q <= 1'b1;
		end else if (irq_clear_i) begin
			irq_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			buffer_q <= 8'h00;
			bf_q     <= 1'b0;
		end else if (load_ev) begin
			buffer_q <= shift_q;
			bf_q     <= 1'b1;
		end else if (buffer_read_i) begin
			bf_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ov_q <= 1'b0;
		end else if (byte_done && accept && !lo_miss && bf_q && !ctrl_i.buffer_override_enable) begin
			ov_q <= 1'b1;
		end else if (overflow_clear_i) begin
			ov_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ack_rx_q   <= 1'b1;
			ack_time_q <= 1'b0;
		end else begin
			if (state_q == ST_ACK && scl_rise) begin
				ack_rx_q <= sda_s;
			end
			if (byte_done && hold_now) begin
				ack_time_q <= 1'b1;
			end else if (ack_fall || start_ev || stop_ev) begin
				ack_time_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ckp_q <= 1'b1;
		end else if (ckp_clr) begin
			ckp_q <= 1'b0;
		end else if (clock_release_set_i) begin
			ckp_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ua_q  <= 1'b0;
			own_q <= OWN_ADDR_RESET;
		end else begin
			if (ua_set) begin
				ua_q <= 1'b1;
			end else if (address_we_i) begin
				ua_q <= 1'b0;
			end
			if (address_we_i) begin
				own_q <= address_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			start_q <= 1'b0;
			stop_q  <= 1'b0;
			rw_q    <= 1'b0;
			da_q    <= 1'b0;
		end else begin
			if (start_ev) begin
				start_q <= 1'b1;
				stop_q  <= 1'b0;
			end else if (stop_ev) begin
				start_q <= 1'b0;
				stop_q  <= 1'b1;
			end
			if (byte_done && accept) begin
				da_q <= (phase_q == PH_DATA);
				if (phase_q == PH_FIRST) begin
					rw_q <= shift_q[0];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			scl_pull_q <= 1'b0;
			sda_pull_q <= 1'b0;
		end else begin
			scl_pull_q <= (!ckp_q && state_q != ST_IDLE) || ua_q || (state_q == ST_HOLD);
			sda_pull_q <= (state_q == ST_ACK) && ack_drive_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_o <= '0;
			status_o.clock_release_bit   <= 1'b1;
			status_o.ack_received_status <= 1'b1;
			own_address_o                <= OWN_ADDR_RESET;
		end else begin
			status_o <= '{rx_tx_buffer: buffer_q, buffer_full_flag: bf_q,
				receive_overflow_flag: ov_q, port_irq_flag: irq_q,
				ack_received_status: ack_rx_q, ack_time_flag: ack_time_q,
				update_address_flag: ua_q, clock_release_bit: ckp_q,
				start_seen: start_q, stop_seen: stop_q, read_write: rw_q,
				data_not_address: da_q};
			own_address_o <= own_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	ack_drive_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_q == ST_ACK && ack_drive_q) |=> sda_pull_q)
		else $error("acknowledge not driven in slot");
	ack_time_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(ack_time_q) |-> (ctrl_i.address_hold_enable || ctrl_i.data_hold_enable))
		else $error("ack-time flag without hold option");
	byte_irq_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(ack_fall && !hold_used_q) |=> irq_q)
		else $error("no interrupt after byte");
	hold_stretch_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(byte_done && hold_now) |=> (irq_q && !ckp_q && state_q == ST_HOLD) ##1 scl_pull_q)
		else $error("hold did not stretch");
	overflow_nack_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(byte_done && blocked && !hold_now) |=> !ack_drive_q ##1 !sda_pull_q)
		else $error("acknowledged while buffer full");
	stop_irq_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(stop_ev && mode_has_sp(ctrl_i.port_mode_select)) |=> (irq_q && stop_q && !start_q))
		else $error("stop interrupt missing");
	ua_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(ua_q && !address_we_i) |=> ua_q && scl_pull_q)
		else $error("update flag lost or clock not held");
	ten_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(byte_done && phase_q == PH_FIRST && ten && shift_q[0] && !prior_q) |=> state_q == ST_IDLE)
		else $error("ten-bit read accepted without prior match");
	mismatch_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(byte_done && !accept) |=> (state_q == ST_IDLE && !bf_q && !$rose(irq_q)))
		else $error("mismatch not silent");
	start_seen_a: assert property (@(posedge clk_i) disable iff (srst_i)
		start_ev |=> (start_q && !stop_q && state_q == ST_RX && bitcnt_q == 4'h0))
		else $error("start not recorded");
	open_drain_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
		(!scl_o && !sda_o))
		else $error("line driven high");

	addr_ack_c: cover property (@(posedge clk_i) disable iff (srst_i)
		ack_fall && ack_drive_q && phase_q == PH_FIRST);
	hold_path_c: cover property (@(posedge clk_i) disable iff (srst_i)
		state_q == ST_HOLD ##[1:1000] state_q == ST_ACK);
	ten_low_c: cover property (@(posedge clk_i) disable iff (srst_i)
		ack_fall && phase_q == PH_LOW);
	stop_c: cover property (@(posedge clk_i) disable iff (srst_i) stop_ev);

endmodule // i2c_slave_address_receive

// ===== design/level_sync.sv
/*
 * Two flip-flop synchroniser for a group of levels.
 * Assumes the input is a level that holds long enough to be seen.
 */
`timescale 1ns/1ps
module level_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= RESET_VAL;
			q_o    <= RESET_VAL;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // level_sync

// ===== include/i2c_slave_pkg.sv
/*
 * Shared constants, mode codes and carrier structs for the two-wire slave
 * address and receive engine.
 * Assumes a single system clock domain for software-facing signals.
 */
package i2c_slave_pkg;

	localparam logic [3:0] BYTE_BITS      = 4'h8;
	localparam logic [7:0] ADDR7_CARE     = 8'hfe;
	localparam logic [7:0] TEN_HI_CARE    = 8'h06;
	localparam logic [4:0] TEN_HI_PREFIX  = 5'h1e;
	localparam int         TEN_A9_BIT     = 2;
	localparam int         TEN_A8_BIT     = 1;
	localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
	localparam logic [1:0] PINS_IDLE      = 2'h3;
	localparam logic [1:0] PULLS_NONE     = 2'h0;

	typedef enum logic [1:0] {
		MODE_SEVEN    = 2'b00,
		MODE_TEN      = 2'b01,
		MODE_SEVEN_SP = 2'b10,
		MODE_TEN_SP   = 2'b11
	} mode_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_HOLD = 3'b010,
		ST_ACK  = 3'b011,
		ST_READ = 3'b100
	} state_type;

	typedef enum logic [1:0] {
		PH_FIRST = 2'b00,
		PH_LOW   = 2'b01,
		PH_DATA  = 2'b10
	} phase_type;

	typedef struct packed {
		mode_type   port_mode_select;
		logic       start_irq_enable;
		logic       stop_irq_enable;
		logic       address_hold_enable;
		logic       data_hold_enable;
		logic       buffer_override_enable;
		logic       stretch_enable;
		logic       ack_value_to_send;
		logic [7:0] address_mask;
	} control_type;

	typedef struct packed {
		logic [7:0] rx_tx_buffer;
		logic       buffer_full_flag;
		logic       receive_overflow_flag;
		logic       port_irq_flag;
		logic       ack_received_status;
		logic       ack_time_flag;
		logic       update_address_flag;
		logic       clock_release_bit;
		logic       start_seen;
		logic       stop_seen;
		logic       read_write;
		logic       data_not_address;
	} status_type;

endpackage

// ===== verif/i2c_master_model.sv
/*
 * Behavioural two-wire bus master that clocks bytes into the slave.
 * Assumes the bench resolves both lines as open-drain wires with pull-ups.
 */
`timescale 1ns/1ps
module i2c_master_model #(
	parameter int HALF_NS = 5000
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// honour clock stretch
	// bounded: a stuck slave shows up as a failed check, not a hang
	task automatic release_scl();
		scl_pull_o = 1'b0;
		for (int i = 0; i < 20000 && scl_i !== 1'b1; i++)
			#100;
		#HALF_NS;
	endtask
	task automatic start();
		sda_pull_o = 1'b0;
		release_scl();
		sda_pull_o = 1'b1;
		#HALF_NS;
		scl_pull_o = 1'b1;
		#HALF_NS;
	endtask
	task automatic stop();
		sda_pull_o = 1'b1;
		#HALF_NS;
		release_scl();
		sda_pull_o = 1'b0;
		#HALF_NS;
	endtask
	task automatic write_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_pull_o = ~b[i];
			#HALF_NS;
			release_scl();
			scl_pull_o = 1'b1;
		end
		sda_pull_o = 1'b0;
		#HALF_NS;
		release_scl();
		ack = sda_i;
		scl_pull_o = 1'b1;
	endtask
endmodule // i2c_master_model

// ===== verif/i2c_slave_address_receive_test.sv
/*
 * Self-checking bench for the two-wire slave address and receive engine.
 * Assumes the master model beside it and pull-ups on both bus lines.
 */
`timescale 1ns/1ps
module i2c_slave_address_receive_test;
	import i2c_slave_pkg::*;
	logic        clk_i = 1'b0;
	logic        link_clk_i = 1'b0;
	logic        srst_i = 1'b1;
	control_type ctrl = '0;
	logic [3:0]  sw_q = 4'h0;
	logic        address_we = 1'b0;
	logic [7:0]  address_wdata = 8'h00;
	status_type  status_o;
	logic [7:0]  own_address_o;
	logic        scl_oe_n_o;
	logic        sda_oe_n_o;
	logic        scl_pull;
	logic        sda_pull;
	logic        ack;
	wire         scl = ~scl_pull & scl_oe_n_o;
	wire         sda = ~sda_pull & sda_oe_n_o;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cycles = 0;

	initial forever #50 clk_i = ~clk_i;
	initial begin
		#3;
		forever #7.5 link_clk_i = ~link_clk_i;
	end

	i2c_slave_address_receive dut (
		.clk_i(clk_i), .srst_i(srst_i), .link_clk_i(link_clk_i),
		.scl_i(scl), .scl_o(), .scl_oe_n_o(scl_oe_n_o),
		.sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n_o), .ctrl_i(ctrl),
		.irq_clear_i(sw_q[3]), .buffer_read_i(sw_q[2]), .overflow_clear_i(sw_q[1]),
		.clock_release_set_i(sw_q[0]), .address_we_i(address_we),
		.address_wdata_i(address_wdata), .status_o(status_o), .own_address_o(own_address_o)
	);
	i2c_master_model m (.scl_i(scl), .sda_i(sda), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t ns %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic settle();
		repeat (12) @(posedge clk_i);
	endtask
	// strobes: irq clear, buffer read, overflow clear, clock release
	task automatic sw(input logic [3:0] s);
		@(posedge clk_i);
		sw_q <= s;
		@(posedge clk_i);
		sw_q <= 4'h0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic set_addr(input logic [7:0] a);
		@(posedge clk_i);
		address_we <= 1'b1;
		address_wdata <= a;
		@(posedge clk_i);
		address_we <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic xfer(input logic [7:0] b, input logic exp_ack);
		m.write_byte(b, ack);
		check(ack, exp_ack, "acknowledge");
		settle();
	endtask
	// software answers the hold, then lets the clock go
	task automatic hold_byte(input logic [7:0] b, input logic exp_ack);
		fork
			m.write_byte(b, ack);
			begin
				for (int i = 0; i < 2000 && status_o.ack_time_flag !== 1'b1; i++)
					@(posedge clk_i);
				settle();
				check(status_o.ack_time_flag, 1'b1, "ack time");
				check(status_o.port_irq_flag, 1'b1, "hold irq");
				check(status_o.clock_release_bit, 1'b0, "hold clock");
				check(scl_oe_n_o, 1'b0, "scl stretched");
				sw(4'hc);
				sw(4'h1);
			end
		join
		check(ack, exp_ack, "software ack");
		settle();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(status_o.clock_release_bit, 1'b1, "release at reset");
		check(status_o.ack_received_status, 1'b1, "ack status at reset");
		check(status_o.port_irq_flag, 1'b0, "irq at reset");
		check(own_address_o, 8'h00, "address at reset");
		check({scl_oe_n_o, sda_oe_n_o}, 8'h03, "lines released");
	endtask
	task automatic t_seven();
		@(posedge clk_i);
		ctrl.port_mode_select <= MODE_SEVEN_SP;
		set_addr(8'ha5);
		m.start();
		settle();
		check(status_o.start_seen, 1'b1, "start seen");
		check(status_o.port_irq_flag, 1'b1, "start irq");
		sw(4'h8);
		xfer(8'ha4, 1'b0);
		check(status_o.rx_tx_buffer, 8'ha4, "address byte");
		check(status_o.read_write, 1'b0, "write direction");
		check(status_o.port_irq_flag, 1'b1, "byte irq");
		check(status_o.ack_received_status, 1'b0, "ack status");
		xfer(8'h3c, 1'b1);
		check(status_o.receive_overflow_flag, 1'b1, "overflow");
		check(status_o.rx_tx_buffer, 8'ha4, "buffer kept");
		sw(4'he);
		m.stop();
		settle();
		check(status_o.stop_seen, 1'b1, "stop seen");
		check(status_o.port_irq_flag, 1'b1, "stop irq");
		sw(4'h8);
		@(posedge clk_i);
		ctrl.port_mode_select <= MODE_SEVEN;
		ctrl.start_irq_enable <= 1'b1;
		m.start();
		settle();
		check(status_o.port_irq_flag, 1'b1, "start irq enable");
		sw(4'h8);
		xfer(8'h10, 1'b1);
		check(status_o.port_irq_flag, 1'b0, "silent mismatch");
		m.stop();
		settle();
	endtask
	task automatic t_hold();
		@(posedge clk_i);
		ctrl.start_irq_enable <= 1'b0;
		ctrl.address_hold_enable <= 1'b1;
		ctrl.data_hold_enable <= 1'b1;
		ctrl.address_mask <= 8'h7e;
		m.start();
		settle();
		sw(4'h8);
		hold_byte(8'h24, 1'b0);
		check(status_o.port_irq_flag, 1'b1, "irq after ack");
		sw(4'hc);
		@(posedge clk_i);
		ctrl.ack_value_to_send <= 1'b1;
		hold_byte(8'h77, 1'b1);
		check(status_o.port_irq_flag, 1'b0, "no irq after nack");
		m.stop();
		settle();
	endtask
	task automatic t_ten();
		@(posedge clk_i);
		ctrl <= '0;
		ctrl.port_mode_select <= MODE_TEN;
		ctrl.address_mask <= 8'hff;
		set_addr(8'h06);
		m.start();
		settle();
		xfer(8'hf6, 1'b0);
		check(status_o.update_address_flag, 1'b1, "high byte flag");
		check(scl_oe_n_o, 1'b0, "held for low address");
		set_addr(8'h5a);
		check(status_o.update_address_flag, 1'b0, "flag cleared");
		check(status_o.rx_tx_buffer, 8'hf6, "high byte loaded");
		// software reads the high byte, else the low byte is refused as overflow
		sw(4'hc);
		xfer(8'h5a, 1'b0);
		check(status_o.update_address_flag, 1'b1, "low byte flag");
		set_addr(8'h06);
		sw(4'hc);
		m.stop();
		settle();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		ctrl.address_mask = 8'hff;
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		t_reset();
		t_seven();
		t_hold();
		t_ten();
		print_verdict();
	end
endmodule // i2c_slave_address_receive_test
